/* fps_poll.sv */
/*
 * Host-side poller for the status word a parallel flash shows while an
 * embedded algorithm runs: polarity or toggle polling, timeout recheck,
 * reset command issue and a time budget.
 * Assumes software issued the program or erase command beforehand and
 * drives the register port with one-cycle strobes.
 */
// Notes on behaviour
// - Status bits 15:8, 4 and 0 are undefined; masked, never used.
// - Polarity bit valid after last write; buffered programs poll last word.
// - Host polls polarity only at the documented valid locations.
// - After polarity turns true, full word comes from a later read.
// - After timeout bit rises, polarity bit is read once more.
// - Erase-started bit is read only after acceptance is confirmed.
// - Toggle check starts with two reads; unchanged means finished.
// - Toggling with timeout bit: recheck; still toggling means fail, reset.
// - Returning to polling restarts from the first double read.
`default_nettype none
`include "fps_defs.svh"

module fps_poll (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic fl_ce_n,
	output logic fl_oe_n,
	output logic fl_we_n,
	output logic [25:0] fl_addr,
	input wire logic [15:0] fl_dq_in,
	output logic [15:0] fl_dq_out,
	output logic fl_dq_oe
);

	localparam fps_pkg::fps_main_t RST = '{st: fps_pkg::FPS_IDLE,
		limit: `FPS_LIMIT_RST, default: '0};

	fps_pkg::fps_main_t cur;
	fps_pkg::fps_main_t nx;
	fps_pkg::fps_req_t req;
	fps_pkg::fps_pins_t pins;
	logic rdy;
	logic done;
	logic tick;
	logic [15:0] rd_w;
	logic [15:0] st_w;
	logic confirm;
	logic over;
	logic [41:0] cw;

	function automatic logic [15:0] fps_mask(input logic [15:0] w);
		return w & `FPS_MASK;
	endfunction

	function automatic logic [41:0] cmd_step(input logic abt,
		input logic [1:0] k, input logic [25:0] pa);
		if (!abt) begin
			return {pa, `FPS_CMD_RESET};
		end else if (k == 2'h0) begin
			return {`FPS_ADR_UNLK1, `FPS_CMD_UNLK1};
		end else if (k == 2'h1) begin
			return {`FPS_ADR_UNLK2, `FPS_CMD_UNLK2};
		end else begin
			return {`FPS_ADR_UNLK1, `FPS_CMD_RESET};
		end
	endfunction

	fps_cycle fps_cycle_inst (
		.clk(clk),
		.arst_n(arst_n),
		.req(req),
		.rdy(rdy),
		.done(done),
		.rdata(rd_w),
		.pins(pins),
		.dq_in(fl_dq_in)
	);

	fps_tick fps_tick_inst (
		.clk(clk),
		.arst_n(arst_n),
		.clr(!cur.busy),
		.tick(tick)
	);

	always_comb begin
		nx = cur;
		nx.rdata = 32'h0;
		req = '0;
		st_w = cur.tog ? cur.b : cur.a;
		// Still busy: bit 7 inverted, or toggle bit flipping
		confirm = cur.tog ?
			(cur.a[`FPS_B_TOG1] != cur.b[`FPS_B_TOG1]) :
			(cur.a[`FPS_B_POL] != cur.expect_w[`FPS_B_POL]);
		over = (cur.us >= cur.limit);
		cw = cmd_step(cur.seq_abt, cur.k, cur.paddr);
		if (tick && cur.busy) begin
			nx.us = cur.us + 24'h000001;
		end

		if (reg_wr) begin
			if (reg_addr == `FPS_REG_CTRL) begin
				if (cur.busy && reg_wdata[`FPS_CTRL_LEAVE]) begin
					nx.lvq = 1'b1;
				end else if (cur.st == fps_pkg::FPS_IDLE) begin
					nx.tog = reg_wdata[`FPS_CTRL_TOG];
					if (reg_wdata[`FPS_CTRL_START] ||
						reg_wdata[`FPS_CTRL_RST]) begin
						nx.busy = 1'b1;
						nx.ok = 1'b0;
						nx.fail = 1'b0;
						nx.ovt = 1'b0;
						nx.abrt = 1'b0;
						nx.es = 1'b0;
						nx.tog2 = 1'b0;
						nx.left = 1'b0;
						nx.lvq = 1'b0;
						nx.rechk = 1'b0;
						nx.us = 24'h000000;
						nx.seq_abt = 1'b0;
						nx.k = 2'h0;
					end
					if (reg_wdata[`FPS_CTRL_START]) begin
						// Always from the first read of a fresh pass
						nx.st = fps_pkg::FPS_RD_A;
					end else if (reg_wdata[`FPS_CTRL_RST]) begin
						nx.st = fps_pkg::FPS_CMD;
					end
				end
			end else if (reg_addr == `FPS_REG_ADDR && !cur.busy) begin
				nx.paddr = reg_wdata[25:0];
			end else if (reg_addr == `FPS_REG_EXP && !cur.busy) begin
				nx.expect_w = reg_wdata[15:0];
			end else if (reg_addr == `FPS_REG_LIMIT && !cur.busy) begin
				nx.limit = reg_wdata[23:0];
			end
		end

		if (reg_rd) begin
			if (reg_addr == `FPS_REG_CTRL) begin
				nx.rdata = {31'h0, cur.tog};
			end else if (reg_addr == `FPS_REG_ADDR) begin
				nx.rdata = {6'h00, cur.paddr};
			end else if (reg_addr == `FPS_REG_EXP) begin
				nx.rdata = {16'h0000, cur.expect_w};
			end else if (reg_addr == `FPS_REG_LIMIT) begin
				nx.rdata = {8'h00, cur.limit};
			end else if (reg_addr == `FPS_REG_STAT) begin
				nx.rdata = {16'h0000, cur.last, cur.left, cur.tog2,
					cur.es, cur.abrt, cur.ovt, cur.fail, cur.ok,
					cur.busy};
			end else if (reg_addr == `FPS_REG_DATA) begin
				nx.rdata = {16'h0000, cur.data};
			end
		end

		case (cur.st)
			fps_pkg::FPS_IDLE: begin
			end
			fps_pkg::FPS_RD_A, fps_pkg::FPS_RD_B,
			fps_pkg::FPS_DATA: begin
				// Software must point at a location that carries status
				req = '{req: !cur.pend, we: 1'b0, addr: cur.paddr,
					wdata: 16'h0000};
				if (done) begin
					if (cur.st == fps_pkg::FPS_RD_A) begin
						nx.a = fps_mask(rd_w);
						nx.st = cur.tog ? fps_pkg::FPS_RD_B :
							fps_pkg::FPS_EVAL;
					end else if (cur.st == fps_pkg::FPS_RD_B) begin
						nx.b = fps_mask(rd_w);
						nx.st = fps_pkg::FPS_EVAL;
					end else begin
						// Other bits may lag bit 7, so the word is taken later
						nx.data = rd_w;
						nx.ok = 1'b1;
						nx.st = fps_pkg::FPS_FIN;
					end
				end
			end
			fps_pkg::FPS_EVAL: begin
				nx.last = st_w[7:0];
				if (confirm) begin
					nx.es = st_w[`FPS_B_ERS];
				end
				if (cur.tog && cur.a[`FPS_B_TOG2] != cur.b[`FPS_B_TOG2]) begin
					nx.tog2 = 1'b1;
				end
				if (!confirm) begin
					nx.st = fps_pkg::FPS_DATA;
				end else if (st_w[`FPS_B_ABT]) begin
					nx.abrt = 1'b1;
					nx.fail = 1'b1;
					nx.seq_abt = 1'b1;
					nx.k = 2'h0;
					nx.st = fps_pkg::FPS_CMD;
				end else if (st_w[`FPS_B_TMO] && !cur.rechk) begin
					// Bit 7 or the toggle may settle with the timeout bit
					nx.rechk = 1'b1;
					nx.st = fps_pkg::FPS_RD_A;
				end else if (st_w[`FPS_B_TMO]) begin
					nx.fail = 1'b1;
					nx.seq_abt = 1'b0;
					nx.k = 2'h0;
					nx.st = fps_pkg::FPS_CMD;
				end else if (over) begin
					// Also ends a protected target that never matches
					nx.ovt = 1'b1;
					nx.fail = 1'b1;
					nx.st = fps_pkg::FPS_FIN;
				end else if (cur.lvq) begin
					nx.left = 1'b1;
					nx.st = fps_pkg::FPS_FIN;
				end else begin
					nx.rechk = 1'b0;
					nx.st = fps_pkg::FPS_RD_A;
				end
			end
			fps_pkg::FPS_CMD: begin
				req = '{req: !cur.pend, we: 1'b1, addr: cw[41:16],
					wdata: cw[15:0]};
				if (done) begin
					if (!cur.seq_abt || cur.k == 2'h2) begin
						nx.st = fps_pkg::FPS_FIN;
					end else begin
						nx.k = cur.k + 2'h1;
					end
				end
			end
			fps_pkg::FPS_FIN: begin
				nx.busy = 1'b0;
				nx.lvq = 1'b0;
				nx.st = fps_pkg::FPS_IDLE;
			end
			default: begin
				nx.st = fps_pkg::FPS_IDLE;
			end
		endcase

		if (done) begin
			nx.pend = 1'b0;
		end else if (req.req && rdy) begin
			nx.pend = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= RST;
		end else begin
			cur <= nx;
		end
	end

	assign reg_rdata = cur.rdata;
	assign fl_ce_n = pins.ce_n;
	assign fl_oe_n = pins.oe_n;
	assign fl_we_n = pins.we_n;
	assign fl_addr = pins.addr;
	assign fl_dq_out = pins.dq_out;
	assign fl_dq_oe = pins.dq_oe;

	AST_MASK: assert property (@(posedge clk) disable iff (!arst_n)
		(cur.a & 16'hff11) == 16'h0000 && (cur.last & 8'h11) == 8'h00)
		else $error("reserved status bits leaked");

	AST_ADDR: assert property (@(posedge clk) disable iff (!arst_n)
		(!fl_oe_n && cur.busy) |-> fl_addr == cur.paddr)
		else $error("status read at wrong address");

	AST_FIRST: assert property (@(posedge clk) disable iff (!arst_n)
		(cur.st == fps_pkg::FPS_IDLE && reg_wr &&
		reg_addr == `FPS_REG_CTRL && reg_wdata[`FPS_CTRL_START])
		|=> cur.st == fps_pkg::FPS_RD_A && !cur.rechk && cur.busy)
		else $error("poll did not restart from first read");

	AST_DATA: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(cur.ok) |-> $past(cur.st) == fps_pkg::FPS_DATA &&
		$past(done))
		else $error("success without a later data read");

	AST_RECHK: assert property (@(posedge clk) disable iff (!arst_n)
		($rose(cur.fail) && !cur.ovt && !cur.abrt) |-> $past(cur.rechk))
		else $error("timeout failure without recheck");

	AST_RST: assert property (@(posedge clk) disable iff (!arst_n)
		($rose(cur.fail) && !cur.ovt) |-> ##[1:20] !fl_we_n)
		else $error("no reset command after failure");

	AST_TOG: assert property (@(posedge clk) disable iff (!arst_n)
		(cur.st == fps_pkg::FPS_EVAL && cur.tog &&
		cur.a[`FPS_B_TOG1] == cur.b[`FPS_B_TOG1])
		|=> cur.st == fps_pkg::FPS_DATA)
		else $error("stopped toggle not taken as finished");

	AST_ES: assert property (@(posedge clk) disable iff (!arst_n)
		$rose(cur.es) |-> $past(cur.st) == fps_pkg::FPS_EVAL &&
		$past(confirm))
		else $error("erase-started taken before acceptance");

	AST_OVT: assert property (@(posedge clk) disable iff (!arst_n)
		(cur.st == fps_pkg::FPS_EVAL && confirm && over &&
		!st_w[`FPS_B_ABT] && !st_w[`FPS_B_TMO]) |=> cur.ovt && cur.fail)
		else $error("poll budget overrun not reported");

	COV_POL_OK: cover property (@(posedge clk) disable iff (!arst_n)
		$rose(cur.ok) && !cur.tog);

	COV_TOG_OK: cover property (@(posedge clk) disable iff (!arst_n)
		$rose(cur.ok) && cur.tog);

	COV_FAIL_RST: cover property (@(posedge clk) disable iff (!arst_n)
		$rose(cur.fail) && !cur.ovt && !cur.abrt);

	COV_ABORT: cover property (@(posedge clk) disable iff (!arst_n)
		$rose(cur.abrt));

endmodule

`default_nettype wire

/* fps_defs.svh */
/*
 * Constants of the flash status poller: register offsets, field
 * positions, reset values, flash command words and timing counts.
 * Assumes a 40 MHz controller clock and a 16-bit flash data bus.
 */
`ifndef FPS_DEFS_SVH
`define FPS_DEFS_SVH

`define FPS_REG_CTRL 8'h00
`define FPS_REG_ADDR 8'h04
`define FPS_REG_EXP 8'h08
`define FPS_REG_LIMIT 8'h0c
`define FPS_REG_STAT 8'h10
`define FPS_REG_DATA 8'h14

`define FPS_CTRL_START 0
`define FPS_CTRL_TOG 1
`define FPS_CTRL_LEAVE 2
`define FPS_CTRL_RST 3

`define FPS_ST_BUSY 0
`define FPS_ST_OK 1
`define FPS_ST_FAIL 2
`define FPS_ST_OVT 3
`define FPS_ST_ABRT 4
`define FPS_ST_ERASE 5
`define FPS_ST_TOG2 6
`define FPS_ST_LEFT 7

`define FPS_B_POL 7
`define FPS_B_TOG1 6
`define FPS_B_TMO 5
`define FPS_B_ERS 3
`define FPS_B_TOG2 2
`define FPS_B_ABT 1
`define FPS_MASK 16'h00ee

`define FPS_CMD_RESET 16'h00f0
`define FPS_CMD_UNLK1 16'h00aa
`define FPS_CMD_UNLK2 16'h0055
`define FPS_ADR_UNLK1 26'h0000555
`define FPS_ADR_UNLK2 26'h00002aa

`define FPS_LIMIT_RST 24'h0f4240

`define FPS_CLK_MHZ 40
`define FPS_TACC_NS 90
`define FPS_TWP_NS 35
`define FPS_TGAP_NS 30
`define FPS_TICK_NS 1000
`define FPS_SYNC_CYC 2
`define FPS_TACC_CYC ((`FPS_TACC_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_TWP_CYC ((`FPS_TWP_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_TGAP_CYC ((`FPS_TGAP_NS * `FPS_CLK_MHZ + 999) / 1000)
`define FPS_TICK_CYC ((`FPS_TICK_NS * `FPS_CLK_MHZ) / 1000)

`endif

/* fps_pkg.sv */
/*
 * Types of the flash status poller: pin bundle, bus request and the
 * state records of each module.
 * Assumes a 26-bit word address and a 16-bit data bus.
 */
`default_nettype none

package fps_pkg;

	typedef struct packed {
		logic ce_n;
		logic oe_n;
		logic we_n;
		logic [25:0] addr;
		logic [15:0] dq_out;
		logic dq_oe;
	} fps_pins_t;

	typedef struct packed {
		logic req;
		logic we;
		logic [25:0] addr;
		logic [15:0] wdata;
	} fps_req_t;

	typedef enum logic [1:0] {
		FPS_CIDLE = 2'b00,
		FPS_CACT = 2'b01,
		FPS_CHOLD = 2'b10
	} fps_cst_t;

	typedef struct packed {
		fps_cst_t st;
		logic [3:0] cnt;
		fps_pins_t pins;
		logic [15:0] s1;
		logic [15:0] s2;
		logic [15:0] rdata;
		logic done;
	} fps_cyc_t;

	typedef struct packed {
		logic [5:0] cnt;
		logic tick;
	} fps_tick_t;

	typedef enum logic [2:0] {
		FPS_IDLE = 3'b000,
		FPS_RD_A = 3'b001,
		FPS_RD_B = 3'b010,
		FPS_EVAL = 3'b011,
		FPS_DATA = 3'b100,
		FPS_CMD = 3'b101,
		FPS_FIN = 3'b110
	} fps_st_t;

	typedef struct packed {
		fps_st_t st;
		logic tog;
		logic [25:0] paddr;
		logic [15:0] expect_w;
		logic [23:0] limit;
		logic [23:0] us;
		logic [15:0] a;
		logic [15:0] b;
		logic [15:0] data;
		logic [7:0] last;
		logic pend;
		logic rechk;
		logic lvq;
		logic seq_abt;
		logic [1:0] k;
		logic busy;
		logic ok;
		logic fail;
		logic ovt;
		logic abrt;
		logic es;
		logic tog2;
		logic left;
		logic [31:0] rdata;
	} fps_main_t;

endpackage

`default_nettype wire

/* fps_tick.sv */
/*
 * Microsecond enable divider for the poll time budget.
 * Assumes the controller clock; clr holds the divider at zero.
 */
`default_nettype none
`include "fps_defs.svh"

module fps_tick (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic clr,
	output logic tick
);

	fps_pkg::fps_tick_t cur;
	fps_pkg::fps_tick_t nx;

	always_comb begin
		nx = cur;
		nx.tick = 1'b0;
		if (clr) begin
			nx.cnt = 6'h00;
		end else if (cur.cnt == 6'(`FPS_TICK_CYC - 1)) begin
			nx.cnt = 6'h00;
			nx.tick = 1'b1;
		end else begin
			nx.cnt = cur.cnt + 6'h01;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= '0;
		end else begin
			cur <= nx;
		end
	end

	assign tick = cur.tick;

endmodule

`default_nettype wire

/* fps_cycle.sv */
/*
 * One asynchronous flash bus cycle per request: a read framed by
 * chip and output enable, or a write framed by chip and write enable.
 * Assumes the flash data pins are asynchronous to clk.
 */
`default_nettype none
`include "fps_defs.svh"

module fps_cycle (
	input wire logic clk,
	input wire logic arst_n,
	input wire fps_pkg::fps_req_t req,
	output logic rdy,
	output logic done,
	output logic [15:0] rdata,
	output fps_pkg::fps_pins_t pins,
	input wire logic [15:0] dq_in
);

	localparam fps_pkg::fps_cyc_t RST = '{st: fps_pkg::FPS_CIDLE,
		pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0},
		default: '0};

	fps_pkg::fps_cyc_t cur;
	fps_pkg::fps_cyc_t nx;

	always_comb begin
		nx = cur;
		nx.done = 1'b0;
		nx.s1 = dq_in;
		nx.s2 = cur.s1;
		case (cur.st)
			fps_pkg::FPS_CIDLE: begin
				if (req.req) begin
					nx.pins.ce_n = 1'b0;
					nx.pins.oe_n = req.we;
					nx.pins.we_n = !req.we;
					nx.pins.addr = req.addr;
					nx.pins.dq_out = req.wdata;
					nx.pins.dq_oe = req.we;
					// Reads wait for the pins to cross the synchroniser
					nx.cnt = req.we ? 4'(`FPS_TWP_CYC - 1) :
						4'(`FPS_TACC_CYC + `FPS_SYNC_CYC - 1);
					nx.st = fps_pkg::FPS_CACT;
				end
			end
			fps_pkg::FPS_CACT: begin
				if (cur.cnt == 4'h0) begin
					nx.rdata = cur.s2;
					nx.done = 1'b1;
					nx.pins.ce_n = 1'b1;
					nx.pins.oe_n = 1'b1;
					nx.pins.we_n = 1'b1;
					nx.cnt = 4'(`FPS_TGAP_CYC - 1);
					nx.st = fps_pkg::FPS_CHOLD;
				end else begin
					nx.cnt = cur.cnt - 4'h1;
				end
			end
			fps_pkg::FPS_CHOLD: begin
				// Data held past the strobe edge, released in the gap
				nx.pins.dq_oe = 1'b0;
				if (cur.cnt == 4'h0) begin
					nx.st = fps_pkg::FPS_CIDLE;
				end else begin
					nx.cnt = cur.cnt - 4'h1;
				end
			end
			default: begin
				nx = RST;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cur <= RST;
		end else begin
			cur <= nx;
		end
	end

	assign rdy = (cur.st == fps_pkg::FPS_CIDLE);
	assign done = cur.done;
	assign rdata = cur.rdata;
	assign pins = cur.pins;

endmodule

`default_nettype wire

/* fps_flash_model.sv */
/*
 * Behavioural flash for the poller bench: status word while busy and not program-suspended,
 * array word otherwise, and a log of command writes.
 * Assumes reads framed by ce_n and oe_n, writes by ce_n and we_n.
 */
`default_nettype none
`include "fps_defs.svh"

module fps_flash_model (
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [25:0] addr,
	input wire logic [15:0] dq_in,
	output logic [15:0] dq
);
	timeunit 1ns;
	timeprecision 1ps;
	logic busy = 1'b0;
	logic erase = 1'b0;
	logic d7 = 1'b0;
	logic tmo = 1'b0;
	logic abt = 1'b0;
	logic tog1 = 1'b0;
	logic tog2 = 1'b0;
	logic [15:0] last = 16'h0000;
	logic prot = 1'b0;
	logic susp = 1'b0;
	int left = 0;
	int nrd = 0;
	int nwr = 0;
	logic [15:0] wd [0:7];
	logic [25:0] wa [0:7];
	wire rd_act = !ce_n && !oe_n;
	wire wr_act = !ce_n && !we_n;

	task automatic arm(input int n, input logic e, input logic b7,
		input logic t, input logic a);
		busy = n > 0;
		left = n;
		erase = e;
		d7 = b7;
		tmo = t;
		abt = a;
		nrd = 0;
		nwr = 0;
		prot = 1'b0;
		susp = 1'b0;
	endtask

	// Same word at every address; undefined bits change per read
	function automatic logic [15:0] word();
		logic [7:0] p;
		logic b7;
		p = 8'(nrd * 59 + 92);
		// Protected target keeps old data; program suspend reads array
		if (!busy || (susp && !erase))
			return {8'h3c, d7 ^ prot, 7'h15};
		// Last busy read shows true bit 7 with the rest still status
		if (susp)
			b7 = 1'b1;
		else if (left == 1 && !prot)
			b7 = d7;
		else
			b7 = erase ? 1'b0 : !d7;
		return {p, b7, tog1, tmo, p[0], erase, tog2, abt,
			!p[0]};
	endfunction

	// Released bus shows the inverse of the last word, never a hold
	always_comb begin
		dq = rd_act ? word() : ~last;
	end

	always @(negedge rd_act) begin
		last = word();
		nrd++;
		if (busy) begin
			// Suspend freezes the algorithm and the first toggle
			if (!susp)
				tog1 = !tog1;
			if (erase)
				tog2 = !tog2;
			if (!susp) begin
				left--;
				if (left == 0)
					busy = 1'b0;
			end
		end
	end

	always @(negedge wr_act) begin
		if (nwr < 8) begin
			wd[nwr] = dq_in;
			wa[nwr] = addr;
		end
		nwr++;
		if (dq_in == `FPS_CMD_RESET)
			busy = 1'b0;
	end
endmodule

`default_nettype wire

/* tb_fps_poll.sv */
/*
 * Bench for the flash status poller: register tasks, one task per
 * scenario, the flash model on the pins.
 * Assumes a 40 MHz clock and one-cycle register strobes.
 */
`default_nettype none
`include "fps_defs.svh"

module tb_fps_poll;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic [31:0] reg_rdata;
	logic [31:0] st;
	logic fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe;
	logic [25:0] fl_addr;
	logic [15:0] fl_dq_out, m_dq;
	wire logic [15:0] fl_dq_in = fl_dq_oe ? fl_dq_out : m_dq;
	int error_cnt = 0;
	int tests_run = 0;

	always #12.5 clk = ~clk;

	fps_poll fps_poll_inst (.clk(clk), .arst_n(arst_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .fl_ce_n(fl_ce_n),
		.fl_oe_n(fl_oe_n), .fl_we_n(fl_we_n), .fl_addr(fl_addr),
		.fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out), .fl_dq_oe(fl_dq_oe));
	fps_flash_model fps_flash_model_inst (.ce_n(fl_ce_n), .oe_n(fl_oe_n),
		.we_n(fl_we_n), .addr(fl_addr), .dq_in(fl_dq_in), .dq(m_dq));

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic test_done();
		$display("Checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Starts a poll and judges the whole flag byte once it ends
	task automatic run(input logic tg, input logic [15:0] ex,
		input logic [25:0] a, input logic [7:0] flags);
		int i;
		wr(`FPS_REG_ADDR, {6'h00, a});
		wr(`FPS_REG_EXP, {16'h0000, ex});
		wr(`FPS_REG_CTRL, {30'h0, tg, 1'b1});
		if (a == 26'h0000abc)
			wr(`FPS_REG_ADDR, 32'h01234567);
		for (i = 0; i < 400; i++) begin
			rd(`FPS_REG_STAT, st);
			if (st[`FPS_ST_BUSY] === 1'b0)
				break;
			if (i == 20 && a == 26'h0000bbb)
				wr(`FPS_REG_CTRL, 32'h6);
		end
		if (i == 400) begin
			check("busy wait", 32'h1, 32'h0);
			test_done();
		end
		check("flags", {24'h0, st[7:0]}, {24'h0, flags});
	endtask

	task automatic t_reset();
		check("pins", {fl_ce_n, fl_oe_n, fl_we_n, fl_dq_oe}, 4'b1110);
		rd(`FPS_REG_STAT, st);
		check("status", st, 32'h0);
		rd(`FPS_REG_LIMIT, st);
		check("limit", st, {8'h00, `FPS_LIMIT_RST});
		rd(8'h3c, st);
		check("unmapped", st, 32'h0);
		$display("Test reset done");
	endtask

	task automatic t_pol_prog();
		fps_flash_model_inst.arm(3, 1'b0, 1'b1, 1'b0, 1'b0);
		run(1'b0, 16'h0080, 26'h0123456, 8'h02);
		rd(`FPS_REG_DATA, st);
		check("data", st, 32'h3c95);
		check("reads", fps_flash_model_inst.nrd, 4);
		$display("Test polarity program done");
	endtask

	task automatic t_tog_erase();
		fps_flash_model_inst.arm(4, 1'b1, 1'b1, 1'b0, 1'b0);
		run(1'b1, 16'hffff, 26'h0200000, 8'h62);
		rd(`FPS_REG_DATA, st);
		check("data", st, 32'h3c95);
		check("reads", fps_flash_model_inst.nrd, 7);
		$display("Test toggle erase done");
	endtask

	task automatic t_tog_tmo();
		fps_flash_model_inst.arm(100000, 1'b0, 1'b0, 1'b1, 1'b0);
		run(1'b1, 16'h0000, 26'h0000abc, 8'h04);
		check("writes", fps_flash_model_inst.nwr, 1);
		check("cmd", fps_flash_model_inst.wd[0], `FPS_CMD_RESET);
		check("cmd addr", fps_flash_model_inst.wa[0], 26'h0000abc);
		rd(`FPS_REG_ADDR, st);
		check("addr kept", st, 32'h00000abc);
		$display("Test toggle timeout done");
	endtask

	task automatic t_pol_tmo();
		fps_flash_model_inst.arm(2, 1'b0, 1'b1, 1'b1, 1'b0);
		run(1'b0, 16'h0080, 26'h0000010, 8'h02);
		check("writes", fps_flash_model_inst.nwr, 0);
		$display("Test polarity recheck done");
	endtask

	task automatic t_abort();
		fps_flash_model_inst.arm(100000, 1'b0, 1'b1, 1'b0, 1'b1);
		run(1'b0, 16'h0080, 26'h0000777, 8'h14);
		check("writes", fps_flash_model_inst.nwr, 3);
		check("w0", fps_flash_model_inst.wd[0], `FPS_CMD_UNLK1);
		check("a0", fps_flash_model_inst.wa[0], `FPS_ADR_UNLK1);
		check("w1", fps_flash_model_inst.wd[1], `FPS_CMD_UNLK2);
		check("a1", fps_flash_model_inst.wa[1], `FPS_ADR_UNLK2);
		check("w2", fps_flash_model_inst.wd[2], `FPS_CMD_RESET);
		check("a2", fps_flash_model_inst.wa[2], `FPS_ADR_UNLK1);
		$display("Test buffer abort done");
	endtask

	task automatic t_leave();
		fps_flash_model_inst.arm(100000, 1'b0, 1'b1, 1'b0, 1'b0);
		run(1'b1, 16'h0080, 26'h0000bbb, 8'h80);
		fps_flash_model_inst.arm(4, 1'b0, 1'b1, 1'b0, 1'b0);
		run(1'b1, 16'h0080, 26'h0000bbc, 8'h02);
		rd(`FPS_REG_CTRL, st);
		check("method", st, 32'h1);
		$display("Test leave and restart done");
	endtask

	task automatic t_rst_cmd();
		int i;
		fps_flash_model_inst.arm(0, 1'b0, 1'b1, 1'b0, 1'b0);
		wr(`FPS_REG_ADDR, 32'h00000321);
		wr(`FPS_REG_CTRL, 32'h8);
		for (i = 0; i < 40 && fps_flash_model_inst.nwr == 0; i++)
			@(posedge clk);
		if (i == 40) begin
			check("cmd wait", 32'h1, 32'h0);
			test_done();
		end
		check("writes", fps_flash_model_inst.nwr, 1);
		check("cmd", fps_flash_model_inst.wd[0], `FPS_CMD_RESET);
		check("cmd addr", fps_flash_model_inst.wa[0], 26'h0000321);
		rd(`FPS_REG_STAT, st);
		check("rst flags", {24'h0, st[7:0]}, 32'h0);
		$display("Test reset command done");
	endtask

	// Erase suspend keeps the second toggle going; program suspend
	// answers with array data only
	task automatic t_susp();
		fps_flash_model_inst.arm(100000, 1'b1, 1'b1, 1'b0, 1'b0);
		fps_flash_model_inst.susp = 1'b1;
		run(1'b1, 16'hffff, 26'h0200040, 8'h42);
		check("reads", fps_flash_model_inst.nrd, 3);
		fps_flash_model_inst.arm(100000, 1'b0, 1'b1, 1'b0, 1'b0);
		fps_flash_model_inst.susp = 1'b1;
		run(1'b0, 16'h0080, 26'h0000200, 8'h02);
		rd(`FPS_REG_DATA, st);
		check("data", st, 32'h3c95);
		check("reads", fps_flash_model_inst.nrd, 2);
		$display("Test suspend done");
	endtask

	// Protected target: status, then old array data that never matches,
	// so only the small budget can end the poll
	task automatic t_over();
		fps_flash_model_inst.arm(3, 1'b0, 1'b1, 1'b0, 1'b0);
		fps_flash_model_inst.prot = 1'b1;
		wr(`FPS_REG_LIMIT, 32'h5);
		run(1'b0, 16'h0080, 26'h0000040, 8'h0c);
		check("writes", fps_flash_model_inst.nwr, 0);
		$display("Test overtime done");
	endtask

	initial begin
		repeat (4) @(posedge clk);
		arst_n <= 1'b1;
		#1;
		t_reset();
		t_pol_prog();
		t_tog_erase();
		t_tog_tmo();
		t_pol_tmo();
		t_abort();
		t_leave();
		t_rst_cmd();
		t_susp();
		t_over();
		test_done();
	end
endmodule

`default_nettype wire
